// File: lrc_pkg.sv
// Purpose: Shared constants and types for the ladder reference control.
// Assumes: AXI4-Lite register access, one 200 MHz clock domain.
// Contract
// - Bit 7 powers the ladder up.
// - Bit 6 requests ladder output on pin.
// - Bit 5 picks low range, else offset.
// - Bit 4 one selects supply rails as source.
// - Bits 3..0 are the unsigned tap index.
// - Any reset clears all eight control bits.
// - Waking from sleep leaves control bits unchanged.
// - Pin routed only if input direction and drive.
// - Works regardless of comparator mode settings.
package lrc_pkg;

    localparam logic [31:0] LRC_CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] LRC_STAT_OFFSET = 32'h0000_0004;
    localparam logic [7:0]  LRC_CTRL_RESET  = 8'h00;

    localparam int LRC_POWER_BIT  = 7;
    localparam int LRC_DRIVE_BIT  = 6;
    localparam int LRC_RANGE_BIT  = 5;
    localparam int LRC_SOURCE_BIT = 4;
    localparam int LRC_TAP_MSB    = 3;
    localparam int LRC_STAT_ROUTE_BIT = 0;

    localparam logic [1:0] LRC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LRC_RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        LRC_ST_IDLE  = 5'h01,
        LRC_ST_WACC  = 5'h02,
        LRC_ST_WRESP = 5'h04,
        LRC_ST_RACC  = 5'h08,
        LRC_ST_RRESP = 5'h10
    } lrc_axi_state_t;

    typedef enum logic [1:0] {
        LRC_SEL_NONE = 2'h0,
        LRC_SEL_CTRL = 2'h1,
        LRC_SEL_STAT = 2'h2
    } lrc_sel_t;

    // Only the word address is decoded; byte offsets inside a word alias.
    function automatic lrc_sel_t lrc_decode(input logic [31:0] addr);
        lrc_sel_t sel;
        sel = LRC_SEL_NONE;
        if (addr[31:2] == LRC_CTRL_OFFSET[31:2])
        begin
            sel = LRC_SEL_CTRL;
        end
        else if (addr[31:2] == LRC_STAT_OFFSET[31:2])
        begin
            sel = LRC_SEL_STAT;
        end
        return sel;
    endfunction : lrc_decode

endpackage : lrc_pkg

// File: lrc_reg_if.sv
// Purpose: Carries control register writes and contents between modules.
// Assumes: Single clock domain, write strobe valid for one cycle.
// Notes: The bus side drives writes, the register side drives contents.
`timescale 1ns/1ps
interface lrc_reg_if;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] ctrl;

    modport bus
    (
        output wr_en,
        output wr_data,
        input  ctrl
    );

    modport store
    (
        input  wr_en,
        input  wr_data,
        output ctrl
    );
endinterface : lrc_reg_if

// File: lrc_ctrl_reg.sv
// Purpose: Holds the eight-bit ladder control register.
// Assumes: Writes arrive as one-cycle strobes from the bus slave.
// Notes: Only reset or a bus write can change the contents.
`timescale 1ns/1ps
module lrc_ctrl_reg
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic aclk_en,
    lrc_reg_if.store  rif
);
    logic [7:0] next_ctrl;

    // Sleep and wake events have no path in here, so contents survive them.
    always_comb
    begin
        next_ctrl = rif.wr_en ? rif.wr_data : rif.ctrl;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rif.ctrl <= lrc_pkg::LRC_CTRL_RESET;
        end
        else if (aclk_en)
        begin
            rif.ctrl <= next_ctrl;
        end
    end

    reset_clears_a: assert property (@(posedge aclk)
        !aresetn |=> rif.ctrl == lrc_pkg::LRC_CTRL_RESET)
        else $error("Control register not cleared by reset.");

    ctrl_holds_a: assert property (@(posedge aclk)
        disable iff (!aresetn) !(aclk_en && rif.wr_en) |=> $stable(rif.ctrl))
        else $error("Control register changed without a write.");

    write_readback_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        aclk_en && rif.wr_en |=> rif.ctrl == $past(rif.wr_data))
        else $error("Control register does not hold the written value.");
endmodule : lrc_ctrl_reg

// File: lrc_pin_route.sv
// Purpose: Gates the ladder output onto the shared analog port pin.
// Assumes: Pin direction input is synchronous, one means input.
// Notes: The switch follows its two conditions one cycle later.
`timescale 1ns/1ps
module lrc_pin_route
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic aclk_en,
    input  wire logic ladder_pin_drive,
    input  wire logic port_a_bit0_direction,
    output logic      pin_route
);
    logic next_pin_route;

    // A digital output on the pin must never meet the ladder output.
    always_comb
    begin
        next_pin_route = ladder_pin_drive && port_a_bit0_direction;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_route <= 1'b0;
        end
        else if (aclk_en)
        begin
            pin_route <= next_pin_route;
        end
    end

    route_gate_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        aclk_en && !(ladder_pin_drive && port_a_bit0_direction)
        |=> !pin_route)
        else $error("Pin routed while direction or drive forbids it.");

    route_opens_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        aclk_en && ladder_pin_drive && port_a_bit0_direction |=> pin_route)
        else $error("Pin not routed although both conditions hold.");
endmodule : lrc_pin_route

// File: lrc_top.sv
// Purpose: AXI4-Lite front end and outputs of the ladder reference control.
// Assumes: aclk_en is high whenever an AXI handshake may occur.
// Notes: Control register at 0x0, read-only status at 0x4.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module lrc_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        aclk_en,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        port_a_bit0_direction,
    output logic             ladder_power_on,
    output logic             ladder_low_range,
    output logic             ladder_source_select,
    output logic [3:0]       ladder_tap_index,
    output logic             analog_port_pin_zero
);
    lrc_pkg::lrc_axi_state_t state;
    lrc_pkg::lrc_axi_state_t next_state;
    lrc_pkg::lrc_sel_t       wsel;
    lrc_pkg::lrc_sel_t       rsel;
    logic [1:0]              next_bresp;
    logic [1:0]              next_rresp;
    logic [31:0]             next_rdata;
    logic                    pin_route;

    lrc_reg_if rif ();

    lrc_ctrl_reg u_ctrl_reg
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .aclk_en (aclk_en),
        .rif     (rif.store)
    );

    lrc_pin_route u_pin_route
    (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .aclk_en               (aclk_en),
        .ladder_pin_drive      (rif.ctrl[lrc_pkg::LRC_DRIVE_BIT]),
        .port_a_bit0_direction (port_a_bit0_direction),
        .pin_route             (pin_route)
    );

    // The ladder controls come straight from the register flops and have no
    // input from any comparator setting, so they never depend on its mode.
    assign ladder_power_on      = rif.ctrl[lrc_pkg::LRC_POWER_BIT];
    assign ladder_low_range     = rif.ctrl[lrc_pkg::LRC_RANGE_BIT];
    assign ladder_source_select = rif.ctrl[lrc_pkg::LRC_SOURCE_BIT];
    assign ladder_tap_index     = rif.ctrl[lrc_pkg::LRC_TAP_MSB:0];
    assign analog_port_pin_zero = pin_route;

    // Ready and valid lines are state bits, so every one is a flop output.
    assign s_axi_awready = state[1];
    assign s_axi_wready  = state[1];
    assign s_axi_bvalid  = state[2];
    assign s_axi_arready = state[3];
    assign s_axi_rvalid  = state[4];

    always_comb
    begin
        wsel = lrc_pkg::lrc_decode(s_axi_awaddr);
        rsel = lrc_pkg::lrc_decode(s_axi_araddr);
    end

    // Writes commit in the handshake cycle; address and data are held by the
    // master there because ready only rises once both valids were seen.
    always_comb
    begin
        rif.wr_en   = aclk_en && (state == lrc_pkg::LRC_ST_WACC)
                      && (wsel == lrc_pkg::LRC_SEL_CTRL)
                      && s_axi_wstrb[0];
        rif.wr_data = s_axi_wdata[7:0];
    end

    always_comb
    begin
        next_state = state;
        next_bresp = s_axi_bresp;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        unique case (state)
            lrc_pkg::LRC_ST_IDLE:
            begin
                // Writes win when both directions arrive together.
                if (s_axi_awvalid && s_axi_wvalid)
                begin
                    next_state = lrc_pkg::LRC_ST_WACC;
                end
                else if (s_axi_arvalid)
                begin
                    next_state = lrc_pkg::LRC_ST_RACC;
                end
            end
            lrc_pkg::LRC_ST_WACC:
            begin
                next_state = lrc_pkg::LRC_ST_WRESP;
                next_bresp = (wsel == lrc_pkg::LRC_SEL_NONE)
                             ? lrc_pkg::LRC_RESP_SLVERR
                             : lrc_pkg::LRC_RESP_OKAY;
            end
            lrc_pkg::LRC_ST_WRESP:
            begin
                if (s_axi_bready)
                begin
                    next_state = lrc_pkg::LRC_ST_IDLE;
                end
            end
            lrc_pkg::LRC_ST_RACC:
            begin
                next_state = lrc_pkg::LRC_ST_RRESP;
                next_rresp = lrc_pkg::LRC_RESP_OKAY;
                unique case (rsel)
                    lrc_pkg::LRC_SEL_CTRL:
                    begin
                        next_rdata = {24'h00_0000, rif.ctrl};
                    end
                    lrc_pkg::LRC_SEL_STAT:
                    begin
                        next_rdata = 32'h0000_0000;
                        next_rdata[lrc_pkg::LRC_STAT_ROUTE_BIT] = pin_route;
                    end
                    default:
                    begin
                        next_rdata = 32'h0000_0000;
                        next_rresp = lrc_pkg::LRC_RESP_SLVERR;
                    end
                endcase
            end
            lrc_pkg::LRC_ST_RRESP:
            begin
                if (s_axi_rready)
                begin
                    next_state = lrc_pkg::LRC_ST_IDLE;
                end
            end
            default:
            begin
                next_state = lrc_pkg::LRC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state       <= lrc_pkg::LRC_ST_IDLE;
            s_axi_bresp <= lrc_pkg::LRC_RESP_OKAY;
            s_axi_rresp <= lrc_pkg::LRC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (aclk_en)
        begin
            state       <= next_state;
            s_axi_bresp <= next_bresp;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence ctrl_write_s;
        aclk_en && s_axi_awready && s_axi_awvalid && s_axi_wvalid
        && (wsel == lrc_pkg::LRC_SEL_CTRL) && s_axi_wstrb[0];
    endsequence

    power_follows_a: assert property (
        ctrl_write_s |=> ladder_power_on == $past(s_axi_wdata[7]))
        else $error("Power control does not follow bit 7.");

    range_follows_a: assert property (
        ctrl_write_s |=> ladder_low_range == $past(s_axi_wdata[5]))
        else $error("Range select does not follow bit 5.");

    source_follows_a: assert property (
        ctrl_write_s |=> ladder_source_select == $past(s_axi_wdata[4]))
        else $error("Source select does not follow bit 4.");

    tap_follows_a: assert property (
        ctrl_write_s |=> ladder_tap_index == $past(s_axi_wdata[3:0]))
        else $error("Tap index does not follow bits 3 to 0.");

    pin_follows_a: assert property (
        ctrl_write_s ##1 (aclk_en && port_a_bit0_direction
        && ladder_power_on && rif.ctrl[lrc_pkg::LRC_DRIVE_BIT])
        |=> analog_port_pin_zero)
        else $error("Pin not routed after drive request.");

    read_back_a: assert property (
        aclk_en && s_axi_arready && s_axi_arvalid
        && (rsel == lrc_pkg::LRC_SEL_CTRL)
        |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(rif.ctrl)})
        else $error("Read data differs from control register.");

    write_answer_a: assert property (
        aclk_en && s_axi_awvalid && s_axi_wvalid && state[0]
        |=> s_axi_awready ##1 s_axi_bvalid)
        else $error("Write response not given two cycles after request.");

    reset_outputs_a: assert property (@(posedge aclk)
        disable iff (1'b0)
        !aresetn |=> !ladder_power_on && !analog_port_pin_zero
        && ladder_tap_index == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("Outputs not cleared by reset.");

    // A handshake pulse lasts one cycle and an answer stands until taken,
    // so a slow master never loses a response.
    wready_pulse_a: assert property (
        aclk_en && s_axi_wready |=> !s_axi_wready)
        else $error("Write ready stood for more than one cycle.");

    arready_pulse_a: assert property (
        aclk_en && s_axi_arready |=> !s_axi_arready)
        else $error("Read address ready stood for more than one cycle.");

    bvalid_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");

    rvalid_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read response changed before it was taken.");

    half_write_a: assert property (
        aclk_en && state[0] && !(s_axi_awvalid && s_axi_wvalid)
        |=> !s_axi_awready && !s_axi_wready)
        else $error("Write taken without both address and data.");

    read_answer_a: assert property (
        aclk_en && state[0] && s_axi_arvalid
        && !(s_axi_awvalid && s_axi_wvalid)
        |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("Read response not given two cycles after request.");

    // Refused writes must leave the register alone; only unmapped ones are answered with an error.
    refused_write_a: assert property (
        aclk_en && s_axi_awready
        && ((wsel != lrc_pkg::LRC_SEL_CTRL) || !s_axi_wstrb[0])
        |=> $stable(rif.ctrl))
        else $error("Control register changed by a refused write.");

    bad_wresp_a: assert property (
        aclk_en && s_axi_awready && (wsel == lrc_pkg::LRC_SEL_NONE)
        |=> s_axi_bresp == lrc_pkg::LRC_RESP_SLVERR)
        else $error("Unmapped write not answered with an error.");

    good_wresp_a: assert property (
        aclk_en && s_axi_awready && (wsel != lrc_pkg::LRC_SEL_NONE)
        |=> s_axi_bresp == lrc_pkg::LRC_RESP_OKAY)
        else $error("Mapped write not answered with okay.");

    bad_rresp_a: assert property (
        aclk_en && s_axi_arready && (rsel == lrc_pkg::LRC_SEL_NONE)
        |=> s_axi_rresp == lrc_pkg::LRC_RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not answered with zero and an error.");

    status_read_a: assert property (
        aclk_en && s_axi_arready && (rsel == lrc_pkg::LRC_SEL_STAT)
        |=> s_axi_rresp == lrc_pkg::LRC_RESP_OKAY
        && s_axi_rdata == {31'h0, $past(analog_port_pin_zero)})
        else $error("Status read does not show the pin route.");

    one_answer_a: assert property (
        !(s_axi_bvalid && s_axi_rvalid))
        else $error("Write and read responses stand together.");

    state_onehot_a: assert property (
        $onehot(state))
        else $error("Bus state is not one-hot.");

    // A low clock enable is how sleep looks from here: nothing may move.
    enable_freeze_a: assert property (
        !aclk_en
        |=> $stable(state) && $stable(rif.ctrl)
        && $stable(analog_port_pin_zero))
        else $error("State moved while the clock enable was low.");

    write_seen_c: cover property (ctrl_write_s ##1 s_axi_bvalid);
    read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
    route_on_c: cover property (analog_port_pin_zero && ladder_power_on);
    bad_addr_c: cover property (s_axi_bvalid
        && s_axi_bresp == lrc_pkg::LRC_RESP_SLVERR);
endmodule : lrc_top

// File: lrc_tb.sv
// Purpose: Self-checking bench for the ladder reference control block.
// Assumes: AXI4-Lite slave answers in its own time; one clock domain.
// Notes: Expected values come from the field layout, never the outputs.
`timescale 1ns/1ps
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        aclk_en = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, dir = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        pwr, low, src, pin;
    logic [3:0]  tap;
    int          num_errors = 0;
    int          n_compared = 0;

    always #2.5 aclk = ~aclk;

    lrc_top dut (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_a_bit0_direction(dir), .ladder_power_on(pwr),
        .ladder_low_range(low), .ladder_source_select(src),
        .ladder_tap_index(tap), .analog_port_pin_zero(pin));

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Address and data are released separately as each is taken.
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0000_00, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || (awready === 1'b1);
            w_ok = w_ok || (wready === 1'b1);
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Reads the control word back and compares it and every field output with the expected word e.
    task automatic expect_ctrl(input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(lrc_pkg::LRC_CTRL_OFFSET, d, r);
        chk(d, {24'h0000_00, e});
        chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_OKAY});
        chk({31'h0, pwr}, {31'h0, e[7]});
        chk({31'h0, low}, {31'h0, e[5]});
        chk({31'h0, src}, {31'h0, e[4]});
        chk({28'h0, tap}, {28'h0, e[3:0]});
        chk({31'h0, pin}, {31'h0, e[6] & dir});
    endtask : expect_ctrl

    task automatic t_fields;
        logic [7:0] pat [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0F,
                                8'h05, 8'h0A, 8'hFF, 8'h00};
        logic [1:0] r;
        foreach (pat[i])
        begin
            wr(lrc_pkg::LRC_CTRL_OFFSET, pat[i], 4'h1, r);
            chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_OKAY});
            expect_ctrl(pat[i]);
        end
    endtask : t_fields

    // Each direction and drive combination, seen on the pin and in status.
    task automatic t_pin_route;
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge aclk);
            dir <= k[0];
            wr(lrc_pkg::LRC_CTRL_OFFSET, {1'b0, k[1], 6'h15}, 4'h1, r);
            repeat (2) @(posedge aclk);
            chk({31'h0, pin}, {31'h0, k[0] & k[1]});
            rd(lrc_pkg::LRC_STAT_OFFSET, d, r);
            chk(d, {31'h0, k[0] & k[1]});
        end
        @(posedge aclk);
        dir <= 1'b1;
    endtask : t_pin_route

    task automatic t_refusals;
        logic [31:0] d;
        logic [1:0]  r;
        wr(lrc_pkg::LRC_CTRL_OFFSET, 8'hC3, 4'h1, r);
        wr(32'h0000_0008, 8'h3C, 4'h1, r);
        chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_SLVERR});
        rd(32'h0000_0008, d, r);
        chk(d, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_SLVERR});
        wr(lrc_pkg::LRC_STAT_OFFSET, 8'h3C, 4'h1, r);
        chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_OKAY});
        wr(lrc_pkg::LRC_CTRL_OFFSET, 8'h3C, 4'h0, r);
        chk({30'h0, r}, {30'h0, lrc_pkg::LRC_RESP_OKAY});
        expect_ctrl(8'hC3);
    endtask : t_refusals

    // A frozen clock enable stands in for sleep, entered powered down.
    task automatic t_hold_and_reset;
        logic [1:0] r;
        wr(lrc_pkg::LRC_CTRL_OFFSET, 8'h77, 4'h1, r);
        @(posedge aclk);
        aclk_en <= 1'b0;
        repeat (10) @(posedge aclk);
        aclk_en <= 1'b1;
        expect_ctrl(8'h77);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        expect_ctrl(8'h00);
    endtask : t_hold_and_reset

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        expect_ctrl(8'h00);
        t_fields();
        t_pin_route();
        t_refusals();
        t_hold_and_reset();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
endmodule : tb
